// file: rtl/pll_cfg.svh
// Purpose: offsets, field positions and reset values of the synthesizer core
// Assumes: byte offsets on a plain register port, 16-bit data
// Notes:   definitions only; included by the core and the divider
//
// Notes on behaviour
// - reference divider counts down each reference rise
// - feedback divider counts down each vco rise
// - reference ratio is register value, 5..32767 or 1
// - ratio one passes reference input straight through
// - reference test pulse high 4.5 input cycles
// - reference test output gated, low, off at reset
// - feedback test output gated, low, off at reset
// - feedback ratio is register value, 40..65535
// - reference output divides by eight after reset
// - single-ended output: vco lead low, lag high
// - polarity bit inverts the single-ended output
// - disabled single-ended output floats high-impedance
// - double-ended outputs pulse low, both when matched
// - polarity bit swaps the double-ended outputs
// - lock indicator high, low pulses on error
// - lock indicator static low until enabled
// - feedback write jam-loads both dividers and detector
// - detector select chooses single or double output
// - lock enable low forces lock indicator low
// - reference output select code table
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH

// register byte offsets
`define PLL_OFS_CFG          4'h0
`define PLL_OFS_REF_DIV      4'h4
`define PLL_OFS_FB_DIV       4'h8
`define PLL_OFS_STATUS       4'hc

// configuration register fields
`define PLL_CFG_POL_BIT      7
`define PLL_CFG_DSEL_BIT     6
`define PLL_CFG_LDE_BIT      5
`define PLL_CFG_OSEL_HI      4
`define PLL_CFG_OSEL_LO      2
`define PLL_CFG_FVE_BIT      1
`define PLL_CFG_FRE_BIT      0

// reset values: in cfg only the reference output select is non-zero (divide by 8); ratios reset to 5 and 40
`define PLL_CFG_RESET        8'h10
`define PLL_REF_DIV_RESET    15'h0005
`define PLL_FB_DIV_RESET     16'h0028

// test pulse lasts this many input half cycles (4.5 cycles)
`define PLL_TEST_PULSE_HALVES 4'h9

`endif

// file: rtl/pll_pkg.sv
// Purpose: shared types of the synthesizer core
// Assumes: nothing beyond the configuration header
// Notes:   select codes of the buffered reference output
package pll_pkg;

    typedef enum logic [2:0]
    {
        PLL_OSEL_LOW  = 3'h0,
        PLL_OSEL_THRU = 3'h1,
        PLL_OSEL_DIV2 = 3'h2,
        PLL_OSEL_DIV4 = 3'h3,
        PLL_OSEL_DIV8 = 3'h4
    } pll_osel_e;

    typedef logic [15:0] pll_word_t;

endpackage

// file: rtl/pll_divider.sv
// Purpose: static down counter with reload, event and test pulse
// Assumes: rise_in and fall_in are one-cycle edge marks of the input pin
// Notes:   ratio one gives an event on every rise
`timescale 1ns/1ps
`include "pll_cfg.svh"
module pll_divider
import pll_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         rise_in,
    input  wire logic         fall_in,
    input  wire logic         jam_in,
    input  wire logic [W-1:0] ratio_in,
    output logic              event_out,
    output logic              pulse_out
);

    logic [W-1:0] count_q;
    logic [3:0]   halves_q;

    // expiry on the rise that finds the count at one
    assign event_out = rise_in && (count_q == W'(1)) && !jam_in;

    // count down by exactly one per rise, reload on expiry or jam
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            count_q <= W'(1);
        else if (jam_in || event_out)
            count_q <= ratio_in;
        else if (rise_in)
            count_q <= count_q - W'(1);
    end

    // test pulse: starts on the event, ends on the ninth following edge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pulse_out <= 1'b0;
            halves_q  <= 4'h0;
        end
        else if (jam_in)
        begin
            pulse_out <= 1'b0;
            halves_q  <= 4'h0;
        end
        else if (event_out)
        begin
            pulse_out <= 1'b1;
            halves_q  <= 4'h0;
        end
        else if (pulse_out && (rise_in || fall_in))
        begin
            if (halves_q == `PLL_TEST_PULSE_HALVES - 4'h1)
                pulse_out <= 1'b0;
            halves_q <= halves_q + 4'h1;
        end
    end

endmodule // pll_divider

// file: rtl/pll_core.sv
// Purpose: dividers, phase detectors, lock indicator and reference output
// Assumes: pin inputs synchronous to clk_in; edges at most every 2 clocks
// Notes:   registers on a plain port, read data one cycle after the strobe
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pll_cfg.svh"
module pll_core
import pll_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        ref_osc_input_in,
    input  wire logic        vco_freq_input_in,
    output logic             buffered_ref_output_out,
    output logic             ref_divider_test_out,
    output logic             vco_divider_test_out,
    output logic             single_ended_detector_out,
    output logic             single_ended_detector_oe_n_out,
    output logic             det_ref_n_out,
    output logic             det_vco_n_out,
    output logic             lock_indicator_out
);

    // configuration and divider registers
    logic [7:0]  cfg_q;
    logic [14:0] ref_ratio_q;
    logic [15:0] fb_ratio_q;
    logic        jam_q;

    // pin history for edge marks
    logic        ref_prev_q;
    logic        vco_prev_q;
    logic        ref_rise;
    logic        ref_fall;
    logic        vco_rise;
    logic        vco_fall;

    // divider results
    logic        ref_event;
    logic        vco_event;
    logic        ref_pulse;
    logic        vco_pulse;

    // detector state
    logic        up_q;
    logic        dn_q;
    logic        up_d;
    logic        dn_d;

    // reference output prescaler
    logic [3:0]  presc_q;
    logic        refo_d;

    // configuration fields
    logic        detector_polarity;
    logic        dsel;
    logic        lock_out_enable;
    logic [2:0]  osel;
    logic        fve;
    logic        fre;

    // next values of the registered outputs
    logic        se_level_d;
    logic        se_drive_d;
    logic        ref_n_d;
    logic        vco_n_d;
    logic        lock_d;
    logic        fr_d;

    assign detector_polarity  = cfg_q[`PLL_CFG_POL_BIT];
    assign dsel = cfg_q[`PLL_CFG_DSEL_BIT];
    assign lock_out_enable  = cfg_q[`PLL_CFG_LDE_BIT];
    assign osel = cfg_q[`PLL_CFG_OSEL_HI:`PLL_CFG_OSEL_LO];
    assign fve  = cfg_q[`PLL_CFG_FVE_BIT];
    assign fre  = cfg_q[`PLL_CFG_FRE_BIT];

    // register writes; reset values give the power-up configuration
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q       <= `PLL_CFG_RESET;
            ref_ratio_q <= `PLL_REF_DIV_RESET;
            fb_ratio_q  <= `PLL_FB_DIV_RESET;
        end
        else if (wr_in)
        begin
            case (addr_in)
                `PLL_OFS_CFG:     cfg_q       <= wdata_in[7:0];
                `PLL_OFS_REF_DIV: ref_ratio_q <= wdata_in[14:0];
                `PLL_OFS_FB_DIV:  fb_ratio_q  <= wdata_in;
                default:          ;
            endcase
        end
    end

    // a feedback write jams both dividers one cycle later, with new value
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            jam_q <= 1'b0;
        else
            jam_q <= wr_in && (addr_in == `PLL_OFS_FB_DIV);
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            case (addr_in)
                `PLL_OFS_CFG:     rdata_out <= {8'h00, cfg_q};
                `PLL_OFS_REF_DIV: rdata_out <= {1'b0, ref_ratio_q};
                `PLL_OFS_FB_DIV:  rdata_out <= fb_ratio_q;
                `PLL_OFS_STATUS:  rdata_out <= {13'h0000, lock_indicator_out,
                                                up_q, dn_q};
                default:          rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end

    // pin history; pins are already synchronous, one stage is enough
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ref_prev_q <= 1'b0;
            vco_prev_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= ref_osc_input_in;
            vco_prev_q <= vco_freq_input_in;
        end
    end

    // edge marks; a stopped pin simply yields no marks
    assign ref_rise = ref_osc_input_in && !ref_prev_q;
    assign ref_fall = !ref_osc_input_in && ref_prev_q;
    assign vco_rise = vco_freq_input_in && !vco_prev_q;
    assign vco_fall = !vco_freq_input_in && vco_prev_q;

    // the two dividers share one counter design
    pll_divider #(.W(15)) u_ref_div
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .rise_in   (ref_rise),
        .fall_in   (ref_fall),
        .jam_in    (jam_q),
        .ratio_in  (ref_ratio_q),
        .event_out (ref_event),
        .pulse_out (ref_pulse)
    );

    pll_divider #(.W(16)) u_vco_div
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .rise_in   (vco_rise),
        .fall_in   (vco_fall),
        .jam_in    (jam_q),
        .ratio_in  (fb_ratio_q),
        .event_out (vco_event),
        .pulse_out (vco_pulse)
    );

    // phase/frequency detector: each event sets its side; once both are
    // set they stand together one cycle, which removes the dead zone
    always_comb
    begin
        up_d = up_q || ref_event;
        dn_d = dn_q || vco_event;
        if (up_q && dn_q)
        begin
            up_d = ref_event;
            dn_d = vco_event;
        end
        if (jam_q)
        begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else
        begin
            up_q <= up_d;
            dn_q <= dn_d;
        end
    end

    // output stage of both detectors and the lock indicator
    always_comb
    begin
        // vco lead (dn only) sinks, lag (up only) sources
        se_drive_d = dsel && (up_q != dn_q);
        se_level_d = up_q ^ detector_polarity;
        if (dsel)
        begin
            ref_n_d = 1'b1;
            vco_n_d = 1'b1;
        end
        else if (detector_polarity)
        begin
            ref_n_d = !dn_q;
            vco_n_d = !up_q;
        end
        else
        begin
            ref_n_d = !up_q;
            vco_n_d = !dn_q;
        end
        // low while either side carries an error; one cycle when matched
        lock_d = lock_out_enable && !(up_q || dn_q);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            single_ended_detector_out      <= 1'b0;
            single_ended_detector_oe_n_out <= 1'b1;
            det_ref_n_out                  <= 1'b1;
            det_vco_n_out                  <= 1'b1;
            lock_indicator_out             <= 1'b0;
        end
        else
        begin
            single_ended_detector_out      <= se_level_d;
            single_ended_detector_oe_n_out <= !se_drive_d;
            det_ref_n_out                  <= ref_n_d;
            det_vco_n_out                  <= vco_n_d;
            lock_indicator_out             <= lock_d;
        end
    end

    // test outputs; ratio one shows the raw reference level instead
    always_comb
    begin
        if (ref_ratio_q == 15'h0001)
            fr_d = ref_osc_input_in;
        else
            fr_d = ref_pulse;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ref_divider_test_out <= 1'b0;
            vco_divider_test_out <= 1'b0;
        end
        else
        begin
            ref_divider_test_out <= fre && fr_d;
            vco_divider_test_out <= fve && vco_pulse;
        end
    end

    // free prescaler on reference rises; bit k divides by 2^(k+1)
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            presc_q <= 4'h0;
        else if (ref_rise)
            presc_q <= presc_q + 4'h1;
    end

    // select codes above divide-by-8 all give divide-by-16
    always_comb
    begin
        case (osel)
            PLL_OSEL_LOW:  refo_d = 1'b0;
            PLL_OSEL_THRU: refo_d = ref_osc_input_in;
            PLL_OSEL_DIV2: refo_d = presc_q[0];
            PLL_OSEL_DIV4: refo_d = presc_q[1];
            PLL_OSEL_DIV8: refo_d = presc_q[2];
            default:       refo_d = presc_q[3];
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            buffered_ref_output_out <= 1'b0;
        else
            buffered_ref_output_out <= refo_d;
    end

endmodule // pll_core

// file: test/pll_core_monitor.sv
// Purpose: port checks of the synthesizer core
// Assumes: cfg mirrored from writes at offset zero
// Notes:   outputs trail cfg by one edge, so both samples must agree
`timescale 1ns/1ps
`include "pll_cfg.svh"
module pll_core_monitor
import pll_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        ref_osc_input_in,
    input wire logic        vco_freq_input_in,
    input wire logic        buffered_ref_output_out,
    input wire logic        ref_divider_test_out,
    input wire logic        vco_divider_test_out,
    input wire logic        single_ended_detector_out,
    input wire logic        single_ended_detector_oe_n_out,
    input wire logic        det_ref_n_out,
    input wire logic        det_vco_n_out,
    input wire logic        lock_indicator_out
);
    logic [7:0] cfg_q, cfg_p, on_w, off_w;
    // mirror of cfg; a one-sample view would flag the write edge itself
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q <= `PLL_CFG_RESET;
            cfg_p <= `PLL_CFG_RESET;
        end
        else
        begin
            cfg_p <= cfg_q;
            if (wr_in && addr_in == `PLL_OFS_CFG)
                cfg_q <= wdata_in[7:0];
        end
    end
    assign on_w  = cfg_q & cfg_p;
    assign off_w = ~(cfg_q | cfg_p);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    se_float_a: assert property (
        off_w[`PLL_CFG_DSEL_BIT] |-> single_ended_detector_oe_n_out)
        else $error("single-ended output driven");
    dbl_high_a: assert property (
        on_w[`PLL_CFG_DSEL_BIT] |-> det_ref_n_out && det_vco_n_out)
        else $error("double-ended output not high");
    lock_low_a: assert property (
        off_w[`PLL_CFG_LDE_BIT] |-> !lock_indicator_out)
        else $error("lock high while disabled");
    fr_off_a: assert property (
        off_w[`PLL_CFG_FRE_BIT] |-> !ref_divider_test_out)
        else $error("ref test output not low");
    fv_off_a: assert property (
        off_w[`PLL_CFG_FVE_BIT] |-> !vco_divider_test_out)
        else $error("vco test output not low");
    buffered_ref_output_low_a: assert property (
        cfg_q[4:2] == PLL_OSEL_LOW && cfg_p[4:2] == PLL_OSEL_LOW
        |-> !buffered_ref_output_out)
        else $error("reference output not low");
    lock_track_a: assert property (
        on_w[`PLL_CFG_LDE_BIT] && off_w[`PLL_CFG_DSEL_BIT]
        |-> lock_indicator_out == (det_ref_n_out && det_vco_n_out))
        else $error("lock disagrees with detector");
    rdata_idle_a: assert property (
        !$past(rd_in) |-> rdata_out == 16'h0)
        else $error("read data outside its cycle");
    cover property (!det_ref_n_out && !det_vco_n_out);
    cover property (!single_ended_detector_oe_n_out);
    cover property (lock_indicator_out [*8]);
endmodule // pll_core_monitor

// file: test/pll_src_model.sv
// Purpose: reference source and vco pins in front of the core
// Assumes: each level held two clocks or more, as the core needs
// Notes:   pins stand still while run_in is low
`timescale 1ns/1ps
module pll_src_model
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic [7:0] ref_half_in,
    input  wire logic [7:0] vco_half_in,
    output logic            ref_osc_out,
    output logic            vco_out
);
    logic [7:0] rc_q, vc_q;
    logic       rt_w, vt_w;
    assign rt_w = rc_q >= ref_half_in - 8'h1;
    assign vt_w = vc_q >= vco_half_in - 8'h1;
    // each pin flips after its half period of clocks
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            {rc_q, vc_q, ref_osc_out, vco_out} <= 18'h0;
        else if (run_in)
        begin
            rc_q        <= rt_w ? 8'h0 : rc_q + 8'h1;
            vc_q        <= vt_w ? 8'h0 : vc_q + 8'h1;
            ref_osc_out <= ref_osc_out ^ rt_w;
            vco_out     <= vco_out ^ vt_w;
        end
    end
endmodule // pll_src_model

// file: test/pll_core_bench.sv
// Purpose: self-checking bench of the synthesizer core
// Assumes: pins at two clocks per level or slower
// Notes:   edge tallies are compared with one count of slack
`timescale 1ns/1ps
`include "pll_cfg.svh"
module pll_core_bench;
    logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic        run_q = 1'b0;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0, rdata_out;
    logic [7:0]  rh_q = 8'h2;
    logic        ro, vo, bo, fr, fv, se, oe_n, dr_n, dv_n, lk;
    logic [4:0]  lvl_q = 5'h0;
    logic [10:0] ev;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, i, k;
    int          cnt [11] = '{default: 0};
    int          st [11], d [11];
    pll_src_model src (.clk_in, .rst_in, .run_in(run_q), .ref_half_in(rh_q),
        .vco_half_in(8'h2), .ref_osc_out(ro), .vco_out(vo));
    pll_core uut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .ref_osc_input_in(ro), .vco_freq_input_in(vo),
        .buffered_ref_output_out(bo), .ref_divider_test_out(fr),
        .vco_divider_test_out(fv), .single_ended_detector_out(se),
        .single_ended_detector_oe_n_out(oe_n), .det_ref_n_out(dr_n),
        .det_vco_n_out(dv_n), .lock_indicator_out(lk));
    // tallies: rises of pins and outputs, low or driven detector cycles
    assign ev = {fr, !lk, !oe_n && !se, !oe_n && se, !dv_n, !dr_n,
                 {fv, vo, fr, bo, ro} & ~lvl_q};
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        lvl_q <= {fv, vo, fr, bo, ro};
        cyc   <= cyc + 1;
        for (int j = 0; j < 11; j++)
            cnt[j] <= cnt[j] + int'(ev[j]);
        // an unknown output would tally as zero and slip past the counts
        if (!rst_in && $isunknown(ev))
        begin
            error_cnt++;
            $display("[ERR] outputs expected known seen %b", ev);
        end
        if (cyc == 60000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g);
        cmp_count++;
        if (g > e + 1 || g < e - 1)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [15:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 chk(nm, e, rdata_out);
    endtask
    // settle a few clocks so a mode change does not leak into the window
    task automatic win(input int n);
        repeat (4) @(posedge clk_in);
        st = cnt;
        repeat (n) @(posedge clk_in);
        for (int j = 0; j < 11; j++)
            d[j] = cnt[j] - st[j];
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk("cfg", `PLL_OFS_CFG, 16'h0010);
        rchk("ref ratio", `PLL_OFS_REF_DIV, 16'h0005);
        rchk("fb ratio", `PLL_OFS_FB_DIV, 16'h0028);
        rchk("unmapped", 4'h2, 16'h0000);
        chk("test outs", 16'h0, {fr, fv});
        chk("lock", 16'h0, lk);
        chk("idle dets", 16'h7, {oe_n, dr_n, dv_n});
        $display("reset test done");
        // 6.25 MHz oscillator stays under the output limit for every code
        run_q <= 1'b1;
        win(512);
        near("buffered_ref_output div8", d[0] / 8, d[1]);
        for (i = 0; i < 8; i++)
        begin
            wr(`PLL_OFS_CFG, 16'(i << 2));
            win(512);
            k = i == 0 ? 0 : d[0] >> (i > 4 ? 4 : i - 1);
            near("buffered_ref_output code", k, d[1]);
        end
        $display("buffered_ref_output test done");
        wr(`PLL_OFS_CFG, 16'h0013);
        wr(`PLL_OFS_FB_DIV, 16'd40);
        win(1600);
        near("ref div", d[0] / 5, d[2]);
        near("fb div", d[3] / 40, d[4]);
        near("ref pulse", 18, d[10] / d[2]);
        rh_q <= 8'h8;
        wr(`PLL_OFS_REF_DIV, 16'h1);
        win(800);
        near("ratio one", d[0], d[2]);
        $display("divider test done");
        // bit 0 polarity, bit 1 single-ended, bit 2 vco faster
        for (i = 0; i < 8; i++)
        begin
            rh_q <= i[2] ? 8'd16 : 8'd2;
            wr(`PLL_OFS_REF_DIV, i[2] ? 16'd6 : 16'd5);
            wr(`PLL_OFS_CFG, {8'h0, i[0], i[1], 6'h30});
            wr(`PLL_OFS_FB_DIV, 16'd40);
            win(2000);
            k = i[0] ^ i[2];
            chk("se side", i[1] ? k : 0, d[8] > d[7]);
            chk("dbl side", i[1] ? 0 : k, d[6] > d[5]);
            chk("idle det", 0, i[1] ? d[5] + d[6] : d[7] + d[8]);
            chk("lock pulses", 1, d[9] > 0);
        end
        rh_q <= 8'd16;
        wr(`PLL_OFS_REF_DIV, 16'd5);
        wr(`PLL_OFS_CFG, 16'h0030);
        wr(`PLL_OFS_FB_DIV, 16'd40);
        win(2000);
        chk("locked", 1, d[9] < 700);
        rh_q <= 8'd2;
        wr(`PLL_OFS_FB_DIV, 16'd40);
        for (k = 0; k < 400 && dr_n !== 1'b0; k++)
            @(posedge clk_in);
        run_q <= 1'b0;
        repeat (8) @(posedge clk_in);
        chk("up holds", 0, dr_n);
        wr(`PLL_OFS_STATUS, 16'hffff);
        rchk("status up", `PLL_OFS_STATUS, 16'h0002);
        wr(`PLL_OFS_FB_DIV, 16'd40);
        repeat (2) @(posedge clk_in);
        #1 chk("jam clears", 3, {dr_n, lk});
        rchk("status jam", `PLL_OFS_STATUS, 16'h0004);
        // a second reset in mid-run must restore the power-up setup
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk("cfg reset", `PLL_OFS_CFG, 16'h0010);
        chk("lock reset", 16'h0, lk);
        $display("detector test done");
        end_sim();
    end
endmodule // pll_core_bench
bind pll_core pll_core_monitor mon (.clk_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .ref_osc_input_in, .vco_freq_input_in,
    .buffered_ref_output_out, .ref_divider_test_out, .vco_divider_test_out,
    .single_ended_detector_out, .single_ended_detector_oe_n_out,
    .det_ref_n_out, .det_vco_n_out, .lock_indicator_out);
